// ==== core/asp_pkg.sv ====
/*
 Constants for the async serial port: register map, field positions, reset values, timing.
 Assumes the bus is classic Wishbone with 32-bit data and word-aligned byte addresses.
*/
package asp_pkg;
   // Register byte offsets
   localparam logic [4:0] ASP_OFF_DATA = 5'h00;
   localparam logic [4:0] ASP_OFF_IER = 5'h04;
   localparam logic [4:0] ASP_OFF_IIR = 5'h08;
   localparam logic [4:0] ASP_OFF_QCR = 5'h0c;
   localparam logic [4:0] ASP_OFF_LCR = 5'h10;
   localparam logic [4:0] ASP_OFF_LSR = 5'h14;
   localparam logic [4:0] ASP_OFF_PWR = 5'h18;
   localparam logic [4:0] ASP_OFF_DIV = 5'h1c;
   // Interrupt enable fields
   localparam int ASP_IER_RDA = 0;
   localparam int ASP_IER_TX_HOLDING_EMPTY = 1;
   localparam int ASP_IER_RLS = 2;
   // Queue control fields
   localparam int ASP_QCR_EN = 0;
   localparam int ASP_QCR_RXCLR = 1;
   localparam int ASP_QCR_TXCLR = 2;
   localparam int ASP_QCR_TRIG = 6;
   // Line control fields
   localparam int ASP_LCR_WLS = 0;
   localparam int ASP_LCR_STB = 2;
   localparam int ASP_LCR_PEN = 3;
   localparam int ASP_LCR_EPS = 4;
   // Power / run control fields
   localparam int ASP_PWR_RXRUN = 13;
   localparam int ASP_PWR_TXRUN = 14;
   // Line status fields
   localparam int ASP_LSR_DR = 0;
   localparam int ASP_LSR_OE = 1;
   localparam int ASP_LSR_PE = 2;
   localparam int ASP_LSR_FE = 3;
   localparam int ASP_LSR_BI = 4;
   localparam int ASP_LSR_TX_HOLDING_EMPTY = 5;
   localparam int ASP_LSR_TEMT = 6;
   localparam int ASP_LSR_RXERR = 7;
   // Interrupt identification codes
   localparam logic [3:0] ASP_IID_NONE = 4'h1;
   localparam logic [3:0] ASP_IID_RLS = 4'h6;
   localparam logic [3:0] ASP_IID_RDA = 4'h4;
   localparam logic [3:0] ASP_IID_TMO = 4'hc;
   localparam logic [3:0] ASP_IID_TX_HOLDING_EMPTY = 4'h2;
   // Reset values
   localparam logic [15:0] ASP_DIV_RST = 16'h0001;
   localparam logic [7:0] ASP_LCR_RST = 8'h03;
   // Oversampling: 16 ticks per bit, sample at tick 8
   localparam logic [3:0] ASP_OVS_LAST = 4'hf;
   localparam logic [3:0] ASP_OVS_MID = 4'h7;
   localparam logic [4:0] ASP_QDEPTH = 5'h10;
   localparam int ASP_TMO_CHARS = 4;
endpackage

// ==== core/asp_queue.sv ====
/*
 Flip-flop queue with count, used for the transmit and receive stages.
 Assumes push is never given while full unless the caller accepts the drop.
*/
`timescale 1ns/100ps
`default_nettype none
module asp_queue #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic clear,
   // Fill side
   input wire logic push,
   input wire logic [WIDTH-1:0] wdata,
   // Drain side
   input wire logic pop,
   output logic [WIDTH-1:0] rdata,
   output logic [$clog2(DEPTH):0] count
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic do_push, do_pop;

   always_comb
   begin
      do_push = push && (cnt_r != (AW+1)'(DEPTH) || pop);
      do_pop = pop && cnt_r != '0;
      wp_nxt = do_push ? wp_r + 1'b1 : wp_r;
      rp_nxt = do_pop ? rp_r + 1'b1 : rp_r;
      cnt_nxt = cnt_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
      if (clear)
      begin
         wp_nxt = '0;
         rp_nxt = '0;
         cnt_nxt = '0;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end
      else
      begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
      if (do_push && !clear)
         mem_r[wp_r] <= wdata;
   end

   assign rdata = mem_r[rp_r];
   assign count = cnt_r;
endmodule
`default_nettype wire

// ==== core/asp_uart.sv ====
/*
 Async serial port: transmitter, receiver, 16-entry queues, interrupt identification.
 Assumes a classic Wishbone master, one 100 MHz clock, serial_in_pin synchronous to clk_sys.
*/
// Added by the designer: the register offsets and the Wishbone register port.
// Behaviour
// - Receive start, five to eight data bits, optional parity, one stop.
// - Transmit start, data, optional parity, then 1, 1.5 or 2 stop bits.
// - Receiver checks only the first stop bit.
// - In queue mode both stages hold sixteen bytes.
// - Words move from holding stage to shift register when it is idle.
// - Non-queue: holding empty interrupt cleared by write or ident read.
// - Queue mode: empty interrupt at empty, cleared by write or ident read.
// - Shift register assembles character into buffer or queue.
// - Each character carries parity, framing and break bits.
// - Non-queue: data-ready interrupt until the character is read.
// - Queue mode: data-ready while fill at or above trigger level.
// - Line-status interrupt on overrun, parity, framing, break; beats data-ready.
// - Data-available set on first character, held until queue empty.
// - Time-out needs data, four idle character times since receive and read.
// - Character time is start, n data, parity, one stop bit.
// - Fired time-out cleared by a read, new character or receiver reset.
// - Timer restarts on each received character or queue read.
// - Queues serviced separately; interrupt or poll by enable bits.
// - Receiver sampling timed by sixteen-times oversampled clock.
// - Eight-bit words use eleven-bit character time, forty-four bit window.
// - Receiver held in reset while receiver-run bit is zero.
`timescale 1ns/100ps
`default_nettype none
module asp_uart
   import asp_pkg::*;
#(
   parameter int QDEPTH = 16
) (
   // System
   input wire logic clk_sys,
   input wire logic rst_b,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Serial pins and interrupt
   input wire logic serial_in_pin,
   output logic serial_out_pin,
   output logic irq
);
   typedef enum logic [2:0] {
      ASP_S_IDLE = 3'b000, ASP_S_START = 3'b001, ASP_S_DATA = 3'b010,
      ASP_S_PAR = 3'b011, ASP_S_STOP = 3'b100
   } asp_state_t;

   function automatic logic [3:0] asp_nbits(input logic [1:0] word_length_select);
      asp_nbits = 4'h5 + {2'b00, word_length_select};
   endfunction

   function automatic logic asp_parity(input logic [7:0] d, input logic [1:0] word_length_select,
                                       input logic even);
      logic [7:0] m;
      m = d & (8'hff >> (2'd3 - word_length_select));
      asp_parity = ^m ^ ~even;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Registers and bus
   logic [2:0] ier_r, ier_nxt;
   logic [7:0] lcr_r, lcr_nxt, qcr_r, qcr_nxt;
   logic rxrun_r, rxrun_nxt, txrun_r, txrun_nxt;
   logic [15:0] div_r, div_nxt;
   logic [31:0] dat_r, dat_nxt;
   logic ack_r, ack_nxt;
   logic req, wr, rd, wr_data, rd_data, rd_iir;
   logic [3:0] iid;
   logic [7:0] line_status_reg;
   logic qen;
   logic [1:0] word_length_select;

   assign req = wb_cyc_i && wb_stb_i && !ack_r;
   assign wr = req && wb_we_i && wb_sel_i[0];
   assign rd = req && !wb_we_i;
   assign wr_data = wr && wb_adr_i == ASP_OFF_DATA;
   assign rd_data = rd && wb_adr_i == ASP_OFF_DATA;
   assign rd_iir = rd && wb_adr_i == ASP_OFF_IIR;
   assign qen = qcr_r[ASP_QCR_EN];
   assign word_length_select = lcr_r[ASP_LCR_WLS +: 2];

   ////////////////////////////////////////////////////////////////////////////
   // Queues; depth one outside queue mode
   logic [4:0] txq_cnt, rxq_cnt;
   logic [7:0] txq_q;
   logic [10:0] rxq_q;
   logic tx_pop, rx_push;
   logic [10:0] rx_word;
   logic tx_full, rx_full;

   assign tx_full = qen ? txq_cnt == ASP_QDEPTH : txq_cnt != 5'h00;
   assign rx_full = qen ? rxq_cnt == ASP_QDEPTH : rxq_cnt != 5'h00;

   asp_queue #(.WIDTH(8), .DEPTH(QDEPTH)) u_txq (
      .clk_sys(clk_sys), .rst_b(rst_b),
      .clear(wr && wb_adr_i == ASP_OFF_QCR && (wb_dat_i[ASP_QCR_TXCLR] ||
             wb_dat_i[ASP_QCR_EN] != qen)),
      .push(wr_data && !tx_full), .wdata(wb_dat_i[7:0]),
      .pop(tx_pop), .rdata(txq_q), .count(txq_cnt)
   );

   // Receive side, character plus three error bits
   asp_queue #(.WIDTH(11), .DEPTH(QDEPTH)) u_rxq (
      .clk_sys(clk_sys), .rst_b(rst_b),
      .clear(wr && wb_adr_i == ASP_OFF_QCR && (wb_dat_i[ASP_QCR_RXCLR] ||
             wb_dat_i[ASP_QCR_EN] != qen)),
      .push(rx_push && !rx_full), .wdata(rx_word),
      .pop(rd_data), .rdata(rxq_q), .count(rxq_cnt)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Baud tick: divisor gives the 16x rate
   logic [15:0] bcnt_r, bcnt_nxt;
   logic tick;
   assign tick = bcnt_r == 16'h0000;
   always_comb
   begin
      bcnt_nxt = tick ? div_r - 16'h0001 : bcnt_r - 16'h0001;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmitter
   asp_state_t ts_r, ts_nxt;
   logic [7:0] tsh_r, tsh_nxt;
   logic [4:0] tov_r, tov_nxt;
   logic [2:0] tbit_r, tbit_nxt;
   logic txo_r, txo_nxt, tpar_r, tpar_nxt;
   logic [4:0] stop_len;

   // Stop length in 16x ticks minus one: 1, 1.5 or 2 bits
   assign stop_len = !lcr_r[ASP_LCR_STB] ? 5'd15 : (word_length_select == 2'd0 ? 5'd23 : 5'd31);

   always_comb
   begin
      ts_nxt = ts_r;
      tsh_nxt = tsh_r;
      tov_nxt = tov_r;
      tbit_nxt = tbit_r;
      txo_nxt = txo_r;
      tpar_nxt = tpar_r;
      tx_pop = 1'b0;
      if (!txrun_r)
      begin
         ts_nxt = ASP_S_IDLE;
         txo_nxt = 1'b1;
      end
      else
         case (ts_r)
            ASP_S_IDLE:
               if (txq_cnt != 5'h00 && tick)
               begin
                  tx_pop = 1'b1;
                  tsh_nxt = txq_q;
                  tpar_nxt = asp_parity(txq_q, word_length_select, lcr_r[ASP_LCR_EPS]);
                  txo_nxt = 1'b0;
                  tov_nxt = 5'd15;
                  ts_nxt = ASP_S_START;
               end
            default:
               if (tick)
               begin
                  tov_nxt = tov_r - 5'd1;
                  if (tov_r == 5'd0)
                  begin
                     tov_nxt = 5'd15;
                     case (ts_r)
                        ASP_S_START:
                        begin
                           ts_nxt = ASP_S_DATA;
                           tbit_nxt = 3'd0;
                           txo_nxt = tsh_r[0];
                        end
                        ASP_S_DATA:
                           if ({1'b0, tbit_r} == asp_nbits(word_length_select) - 4'h1)
                           begin
                              ts_nxt = lcr_r[ASP_LCR_PEN] ? ASP_S_PAR : ASP_S_STOP;
                              txo_nxt = lcr_r[ASP_LCR_PEN] ? tpar_r : 1'b1;
                              tov_nxt = lcr_r[ASP_LCR_PEN] ? 5'd15 : stop_len;
                           end
                           else
                           begin
                              tbit_nxt = tbit_r + 3'd1;
                              tsh_nxt = tsh_r >> 1;
                              txo_nxt = tsh_r[1];
                           end
                        ASP_S_PAR:
                        begin
                           ts_nxt = ASP_S_STOP;
                           txo_nxt = 1'b1;
                           tov_nxt = stop_len;
                        end
                        default:
                           ts_nxt = ASP_S_IDLE;
                     endcase
                  end
               end
         endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receiver, sampled mid-bit on the 16x tick
   asp_state_t rs_r, rs_nxt;
   logic [7:0] rsh_r, rsh_nxt;
   logic [3:0] rov_r, rov_nxt;
   logic [2:0] rbit_r, rbit_nxt;
   logic rpe_r, rpe_nxt, rlow_r, rlow_nxt;

   always_comb
   begin
      rs_nxt = rs_r;
      rsh_nxt = rsh_r;
      rov_nxt = rov_r;
      rbit_nxt = rbit_r;
      rpe_nxt = rpe_r;
      rlow_nxt = rlow_r;
      rx_push = 1'b0;
      rx_word = {1'b0, 1'b0, rpe_r, rsh_r};
      if (!rxrun_r)
         rs_nxt = ASP_S_IDLE;
      else if (tick)
      begin
         rov_nxt = rov_r + 4'h1;
         case (rs_r)
            ASP_S_IDLE:
               if (!serial_in_pin)
               begin
                  rs_nxt = ASP_S_START;
                  rov_nxt = 4'h0;
               end
            ASP_S_START:
               if (rov_r == ASP_OVS_MID)
               begin
                  rov_nxt = 4'h0;
                  rs_nxt = serial_in_pin ? ASP_S_IDLE : ASP_S_DATA;
                  rbit_nxt = 3'd0;
                  rsh_nxt = 8'h00;
                  rlow_nxt = 1'b1;
               end
            ASP_S_DATA:
               if (rov_r == ASP_OVS_LAST)
               begin
                  rsh_nxt = {serial_in_pin, rsh_r[7:1]};
                  rlow_nxt = rlow_r & ~serial_in_pin;
                  rbit_nxt = rbit_r + 3'd1;
                  if ({1'b0, rbit_r} == asp_nbits(word_length_select) - 4'h1)
                     rs_nxt = lcr_r[ASP_LCR_PEN] ? ASP_S_PAR : ASP_S_STOP;
               end
            ASP_S_PAR:
               if (rov_r == ASP_OVS_LAST)
               begin
                  rsh_nxt = rsh_r >> (4'h8 - asp_nbits(word_length_select));
                  rpe_nxt = serial_in_pin != asp_parity(rsh_r >> (4'h8 - asp_nbits(word_length_select)),
                            word_length_select, lcr_r[ASP_LCR_EPS]);
                  rlow_nxt = rlow_r & ~serial_in_pin;
                  rs_nxt = ASP_S_STOP;
               end
            default:
               if (rov_r == ASP_OVS_LAST)
               begin
                  // Further stop bits fall into idle and are never seen
                  rs_nxt = ASP_S_IDLE;
                  rx_push = 1'b1;
                  rx_word[7:0] = lcr_r[ASP_LCR_PEN] ? rsh_r : rsh_r >> (4'h8 - asp_nbits(word_length_select));
                  rx_word[8] = lcr_r[ASP_LCR_PEN] & rpe_r;
                  rx_word[9] = !serial_in_pin;
                  rx_word[10] = rlow_r && !serial_in_pin;
                  if (rx_word[10])
                     rx_word[7:0] = 8'h00;
                  rpe_nxt = 1'b0;
               end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status, time-out and interrupt identification
   logic oe_r, oe_nxt, lse_r, lse_nxt, tx_holding_empty_r, tx_holding_empty_nxt, tmo_r, tmo_nxt;
   logic [9:0] tmo_cnt_r, tmo_cnt_nxt;
   logic [9:0] tmo_lim;
   logic [3:0] trig;
   logic tx_empty_now, rda, rx_err_any;

   // Four char times in 16x ticks: (n + 3) bits each
   assign tmo_lim = 10'(ASP_TMO_CHARS * 16) * 10'(asp_nbits(word_length_select) + 4'h3);
   assign trig = qcr_r[ASP_QCR_TRIG +: 2] == 2'd0 ? 4'd1 :
                 qcr_r[ASP_QCR_TRIG +: 2] == 2'd1 ? 4'd4 :
                 qcr_r[ASP_QCR_TRIG +: 2] == 2'd2 ? 4'd8 : 4'd14;
   assign rda = qen ? rxq_cnt >= {1'b0, trig} : rxq_cnt != 5'h00;
   assign tx_empty_now = txq_cnt == 5'h00;

   always_comb
   begin
      oe_nxt = oe_r | (rx_push & rx_full);
      lse_nxt = lse_r | (rx_push & |rx_word[10:8]) | (rx_push & rx_full);
      // Set on becoming empty; a write or ident read clears it
      tx_holding_empty_nxt = tx_holding_empty_r;
      if (wr_data || rd_iir)
         tx_holding_empty_nxt = 1'b0;
      // A push in the same cycle keeps the stage busy, so no set then
      if (tx_pop && txq_cnt == 5'h01 &&
          !(wr_data && !tx_full))
         tx_holding_empty_nxt = 1'b1;
      if (rd && wb_adr_i == ASP_OFF_LSR)
      begin
         oe_nxt = rx_push & rx_full;
         lse_nxt = rx_push & (rx_full | |rx_word[10:8]);
      end
      tmo_cnt_nxt = tmo_cnt_r;
      tmo_nxt = tmo_r;
      if (rx_push || rd_data || !rxrun_r || rxq_cnt == 5'h00)
      begin
         tmo_cnt_nxt = 10'd0;
         tmo_nxt = 1'b0;
      end
      else if (tick && !tmo_r)
      begin
         tmo_cnt_nxt = tmo_cnt_r + 10'd1;
         if (tmo_cnt_r >= tmo_lim)
            tmo_nxt = qen;
      end
   end

   assign rx_err_any = rxq_cnt != 5'h00 && |rxq_q[10:8];
   assign line_status_reg = {rx_err_any, tx_empty_now && ts_r == ASP_S_IDLE, tx_empty_now,
                 rxq_q[10] && rxq_cnt != 5'h00, rxq_q[9] && rxq_cnt != 5'h00,
                 (rxq_q[8] && rxq_cnt != 5'h00) , oe_r, rxq_cnt != 5'h00};

   // Each source gated by an enable, time-out sharing the data-ready one; polling uses lsr instead
   always_comb
   begin
      if (ier_r[ASP_IER_RLS] && (lse_r || oe_r))
         iid = ASP_IID_RLS;
      else if (ier_r[ASP_IER_RDA] && rda)
         iid = ASP_IID_RDA;
      else if (ier_r[ASP_IER_RDA] && tmo_r)
         iid = ASP_IID_TMO;
      else if (ier_r[ASP_IER_TX_HOLDING_EMPTY] && tx_holding_empty_r)
         iid = ASP_IID_TX_HOLDING_EMPTY;
      else
         iid = ASP_IID_NONE;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register writes and read mux
   always_comb
   begin
      ier_nxt = ier_r;
      lcr_nxt = lcr_r;
      qcr_nxt = qcr_r;
      rxrun_nxt = rxrun_r;
      txrun_nxt = txrun_r;
      div_nxt = div_r;
      ack_nxt = req;
      dat_nxt = 32'h0000_0000;
      if (wr)
         case (wb_adr_i)
            ASP_OFF_IER: ier_nxt = wb_dat_i[2:0];
            ASP_OFF_QCR: qcr_nxt = wb_dat_i[7:0] & 8'hc1;
            ASP_OFF_LCR: lcr_nxt = wb_dat_i[7:0];
            ASP_OFF_DIV: div_nxt = wb_sel_i[1] ? wb_dat_i[15:0] : {div_r[15:8], wb_dat_i[7:0]};
            default: ;
         endcase
      if (req && wb_we_i && wb_adr_i == ASP_OFF_PWR && wb_sel_i[1])
      begin
         rxrun_nxt = wb_dat_i[ASP_PWR_RXRUN];
         txrun_nxt = wb_dat_i[ASP_PWR_TXRUN];
      end
      if (rd)
         case (wb_adr_i)
            ASP_OFF_DATA: dat_nxt = {24'h000000, rxq_q[7:0]};
            ASP_OFF_IER: dat_nxt = {29'h0, ier_r};
            ASP_OFF_IIR: dat_nxt = {24'h000000, qen, qen, 2'b00, iid};
            ASP_OFF_QCR: dat_nxt = {24'h000000, qcr_r};
            ASP_OFF_LCR: dat_nxt = {24'h000000, lcr_r};
            ASP_OFF_LSR: dat_nxt = {24'h000000, line_status_reg};
            ASP_OFF_PWR: dat_nxt = {17'h0, txrun_r, rxrun_r, 13'h0};
            ASP_OFF_DIV: dat_nxt = {16'h0000, div_r};
            default: dat_nxt = 32'h0000_0000;
         endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         ier_r <= 3'h0;
         lcr_r <= ASP_LCR_RST;
         qcr_r <= 8'h00;
         rxrun_r <= 1'b0;
         txrun_r <= 1'b0;
         div_r <= ASP_DIV_RST;
         dat_r <= 32'h0000_0000;
         ack_r <= 1'b0;
         bcnt_r <= 16'h0000;
         ts_r <= ASP_S_IDLE;
         tsh_r <= 8'h00;
         tov_r <= 5'h00;
         tbit_r <= 3'h0;
         txo_r <= 1'b1;
         tpar_r <= 1'b0;
         rs_r <= ASP_S_IDLE;
         rsh_r <= 8'h00;
         rov_r <= 4'h0;
         rbit_r <= 3'h0;
         rpe_r <= 1'b0;
         rlow_r <= 1'b0;
         oe_r <= 1'b0;
         lse_r <= 1'b0;
         tx_holding_empty_r <= 1'b1;
         tmo_r <= 1'b0;
         tmo_cnt_r <= 10'h000;
      end
      else
      begin
         ier_r <= ier_nxt;
         lcr_r <= lcr_nxt;
         qcr_r <= qcr_nxt;
         rxrun_r <= rxrun_nxt;
         txrun_r <= txrun_nxt;
         div_r <= div_nxt;
         dat_r <= dat_nxt;
         ack_r <= ack_nxt;
         bcnt_r <= bcnt_nxt;
         ts_r <= ts_nxt;
         tsh_r <= tsh_nxt;
         tov_r <= tov_nxt;
         tbit_r <= tbit_nxt;
         txo_r <= txo_nxt;
         tpar_r <= tpar_nxt;
         rs_r <= rs_nxt;
         rsh_r <= rsh_nxt;
         rov_r <= rov_nxt;
         rbit_r <= rbit_nxt;
         rpe_r <= rpe_nxt;
         rlow_r <= rlow_nxt;
         oe_r <= oe_nxt;
         lse_r <= lse_nxt;
         tx_holding_empty_r <= tx_holding_empty_nxt;
         tmo_r <= tmo_nxt;
         tmo_cnt_r <= tmo_cnt_nxt;
      end
   end

   assign wb_dat_o = dat_r;
   assign wb_ack_o = ack_r;
   assign serial_out_pin = txo_r;
   assign irq = iid != ASP_IID_NONE;
endmodule
`default_nettype wire

// ==== tb/asp_uart_asserts.sv ====
/*
 Port checker for asp_uart, bound to every instance.
 Assumes the reset divisor of one, so a bit lasts 16 clocks.
*/
`timescale 1ns/100ps
`default_nettype none
module asp_uart_asserts (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Pins
   input wire logic serial_out_pin,
   input wire logic irq
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_next_edge: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_data_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   a_reset_idle: assert property (!$past(rst_b) |-> serial_out_pin && !irq)
      else $error("line or irq not idle after reset");
   a_low_min_bit: assert property ($fell(serial_out_pin) |-> !serial_out_pin [*8])
      else $error("low bit too short");
   a_high_min_bit: assert property ($rose(serial_out_pin) |-> serial_out_pin [*8])
      else $error("high bit too short");
   a_frame_ends: assert property ($fell(serial_out_pin) |-> ##[1:200] serial_out_pin)
      else $error("line stuck low");
   // Main scenarios reached
   c_ack: cover property (wb_ack_o);
   c_frame: cover property ($fell(serial_out_pin));
   c_irq: cover property ($rose(irq));
endmodule
////////////////////////////////////////////////////////////////
bind asp_uart asp_uart_asserts i_asp_uart_asserts (.clk_sys, .rst_b, .wb_cyc_i, .wb_stb_i,
   .wb_dat_o, .wb_ack_o, .serial_out_pin, .irq);
`default_nettype wire

// ==== tb/asp_remote.sv ====
/*
 Remote serial device: sends frames into the port and captures its output.
 Assumes 16 clocks per bit; line idles high between frames.
*/
`timescale 1ns/100ps
`default_nettype none
module asp_remote (
   // Clock
   input wire logic clk_sys,
   // Serial lines
   input wire logic serial_out_pin,
   output logic serial_in_pin
);
   initial serial_in_pin = 1'b1;
   // Start, n data bits LSB first, parity, one stop
   task automatic send(input logic [7:0] d, input int n, input logic p, input logic s);
      for (int i = 0; i < n + 3; i++)
      begin
         @(posedge clk_sys);
         serial_in_pin <= (i == 0) ? 1'b0 : (i <= n) ? d[i-1] : (i == n + 1) ? p : s;
         repeat (15) @(posedge clk_sys);
      end
      @(posedge clk_sys);
      serial_in_pin <= 1'b1;
   endtask
   // Mid-bit samples of data, parity and stop
   task automatic catch_frame(input int n, output logic [9:0] b);
      int k;
      b = 10'h0;
      k = 0;
      while (serial_out_pin !== 1'b0 && k++ < 4000) @(posedge clk_sys);
      repeat (8) @(posedge clk_sys);
      for (int i = 0; i < n + 2; i++)
      begin
         repeat (16) @(posedge clk_sys);
         b[i] = serial_out_pin;
      end
   endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
/*
 Self-checking bench for asp_uart with a remote serial partner.
 Assumes reset register values and a divisor of one.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import asp_pkg::*;
;
   logic clk_sys, rst_b, req, we;
   logic [4:0] adr;
   logic [31:0] dat, rd;
   wire logic [31:0] wb_dat_o;
   wire logic wb_ack_o, serial_in_pin, serial_out_pin, irq;
   int mismatches = 0;
   int compares = 0;
   asp_uart i_asp_uart (.clk_sys, .rst_b, .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o, .wb_ack_o,
      .serial_in_pin, .serial_out_pin, .irq);
   asp_remote i_asp_remote (.clk_sys, .serial_out_pin, .serial_in_pin);
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   ////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      mismatches += int'(g !== e);
      if (g !== e) $display("unexpected %s: expected %h seen %h", nm, e, g);
   endtask
   task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      req <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      @(posedge clk_sys);
      while (wb_ack_o !== 1'b1 && n++ < 20) @(posedge clk_sys);
      mismatches += int'(n > 20);
      rd = wb_dat_o;
      req <= 1'b0;
   endtask
   task automatic t_tx;
      logic [9:0] b, m, e;
      for (int w = 0; w < 4; w++)
      begin
         m = 10'((1 << (5 + w)) - 1);
         e = (10'h096 & m) | ({9'h0, ^(m[7:0] & 8'h96)} << (5 + w)) | (10'h1 << (6 + w));
         wb(1'b1, ASP_OFF_LCR, 32'h18 | w);
         wb(1'b1, ASP_OFF_DATA, 32'h96);
         i_asp_remote.catch_frame(5 + w, b);
         chk("tx_frame", 32'(e), 32'(b));
      end
   endtask
   task automatic t_rx;
      logic [7:0] d;
      wb(1'b1, ASP_OFF_IER, 32'h4);
      for (int i = 0; i < 3; i++)
      begin
         d = 8'h5a + 8'(i);
         i_asp_remote.send(d, 8, ^d ^ (i == 1), i != 2);
         chk("irq_line", {31'h0, i != 0}, {31'h0, irq});
         wb(1'b0, ASP_OFF_LSR, 32'h0);
         chk("lsr_flags", {28'h0, i == 2, i == 1, 2'b01}, {28'h0, rd[3:0]});
         wb(1'b0, ASP_OFF_DATA, 32'h0);
         chk("rx_data", 32'(d), {24'h0, rd[7:0]});
      end
      // A low stop may start a stray frame; let it land and drain it
      repeat (200) @(posedge clk_sys);
      wb(1'b0, ASP_OFF_DATA, 32'h0);
      wb(1'b0, ASP_OFF_LSR, 32'h0);
   endtask
   task automatic t_irq;
      logic [9:0] b;
      wb(1'b1, ASP_OFF_IER, 32'h2);
      @(negedge clk_sys);
      chk("irq_tx_holding_empty", 32'h1, {31'h0, irq});
      wb(1'b0, ASP_OFF_IIR, 32'h0);
      chk("iir_tx_holding_empty", 32'(ASP_IID_TX_HOLDING_EMPTY), {28'h0, rd[3:0]});
      @(negedge clk_sys);
      chk("irq_ident", 32'h0, {31'h0, irq});
      wb(1'b1, ASP_OFF_DATA, 32'h11);
      wb(1'b1, ASP_OFF_IER, 32'h1);
      i_asp_remote.catch_frame(8, b);
      i_asp_remote.send(8'h42, 8, ^8'h42, 1'b1);
      @(negedge clk_sys);
      chk("irq_rda", 32'h1, {31'h0, irq});
      wb(1'b0, ASP_OFF_IIR, 32'h0);
      chk("iir_rda", 32'(ASP_IID_RDA), {28'h0, rd[3:0]});
      wb(1'b0, ASP_OFF_DATA, 32'h0);
      @(negedge clk_sys);
      chk("irq_read", 32'h0, {31'h0, irq});
   endtask
   task automatic t_queue;
      wb(1'b1, ASP_OFF_QCR, 32'h41);
      repeat (3) i_asp_remote.send(8'h33, 8, ^8'h33, 1'b1);
      repeat (600) @(posedge clk_sys);
      chk("irq_below", 32'h0, {31'h0, irq});
      repeat (200) @(posedge clk_sys);
      wb(1'b0, ASP_OFF_IIR, 32'h0);
      chk("iir_tmo", 32'(ASP_IID_TMO), {28'h0, rd[3:0]});
      wb(1'b0, ASP_OFF_DATA, 32'h0);
      @(negedge clk_sys);
      chk("tmo_clear", 32'h0, {31'h0, irq});
      repeat (2) i_asp_remote.send(8'h34, 8, ^8'h34, 1'b1);
      wb(1'b0, ASP_OFF_IIR, 32'h0);
      chk("iir_trig", 32'(ASP_IID_RDA), {28'h0, rd[3:0]});
      wb(1'b0, ASP_OFF_DATA, 32'h0);
      @(negedge clk_sys);
      chk("trig_drop", 32'h0, {31'h0, irq});
   endtask
   task automatic close_out;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   // Whole run needs about 3700 cycles
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      mismatches++;
      close_out();
   end
   initial
   begin
      rst_b = 1'b0;
      req = 1'b0;
      we = 1'b0;
      adr = 5'h0;
      dat = 32'h0;
      repeat (20) @(posedge clk_sys);
      rst_b <= 1'b1;
      wb(1'b1, ASP_OFF_LCR, 32'h1b);
      i_asp_remote.send(8'h3c, 8, ^8'h3c, 1'b1);
      wb(1'b0, ASP_OFF_LSR, 32'h0);
      chk("rx_held", 32'h0, {31'h0, rd[ASP_LSR_DR]});
      wb(1'b1, ASP_OFF_PWR, 32'h6000);
      t_tx();
      t_rx();
      t_irq();
      t_queue();
      close_out();
   end
endmodule
`default_nettype wire
